// *** hw/upf_pkg.sv ***
// Package for the USB port status flag bank
package upf_pkg;
    // Register offsets
    localparam logic [7:0] UPF_OFS_P2_FAULT = 8'h04;
    localparam logic [7:0] UPF_OFS_P1_GEN = 8'h0f;
    localparam logic [7:0] UPF_OFS_P2_GEN = 8'h10;
    // Port 2 fault flag bit positions
    localparam int UPF_FLT_OVERCUR = 0;
    localparam int UPF_FLT_BACKV = 1;
    localparam int UPF_FLT_ERROR = 7;
    // General flag bit positions
    localparam int UPF_GEN_ATTACH = 0;
    localparam int UPF_GEN_REMOVAL = 1;
    localparam int UPF_GEN_LOWCUR = 2;
    localparam int UPF_GEN_SWITCH = 3;
    localparam int UPF_GEN_CC = 4;
    localparam int UPF_GEN_QUOTA = 7;
    // Reset values
    localparam logic [7:0] UPF_RST_FLAGS = 8'h00;
    localparam logic [7:0] UPF_RST_RDATA = 8'h00;
    // Back-voltage margin, resolved by the analog comparator
    localparam int UPF_BACKV_MARGIN_MV = 150;

    // Register access request from the serial bus engine
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } upf_bus_req_s;

    // Register read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } upf_bus_rsp_s;

    // Per-port status inputs
    typedef struct packed {
        logic quota_reached;
        logic quota_reset_bit;
        logic quota_enable_bit;
        logic const_current;
        logic switch_en_pin;
        logic switch_enable_override;
        logic low_charge_current;
        logic removal_event;
        logic attach_event;
    } upf_port_in_s;

    // Port 2 analog comparator results
    typedef struct packed {
        logic above_current_limit;
        logic above_min_current;
        logic vbus_above_source;
        logic vbus_above_supply;
    } upf_p2_cmp_s;
endpackage

// *** hw/upf_port_flags.sv ***
// Per-port general status flag register
`timescale 1ns/100ps
module upf_port_flags
    import upf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_q_b,
    // Port status and read clear
    input wire upf_port_in_s pin,
    input wire logic rd_clr,
    // Register contents
    output logic [7:0] flags
);
    logic quota;
    logic lowcur;
    logic removal;
    logic next_quota;
    logic next_lowcur;
    logic next_removal;
    logic quota_auto_clr;
    logic [7:0] next_flags;

    assign quota_auto_clr = pin.quota_reset_bit | ~pin.quota_enable_bit;
    assign next_quota = pin.quota_reached |
        (quota & ~rd_clr & ~quota_auto_clr);
    assign next_lowcur = pin.low_charge_current | (lowcur & ~rd_clr);
    assign next_removal = pin.removal_event | (removal & ~rd_clr);

    always_comb begin
        next_flags = 8'h00;
        next_flags[UPF_GEN_QUOTA] = next_quota;
        next_flags[UPF_GEN_CC] = pin.const_current;
        next_flags[UPF_GEN_SWITCH] = pin.switch_en_pin |
            pin.switch_enable_override;
        next_flags[UPF_GEN_LOWCUR] = next_lowcur;
        next_flags[UPF_GEN_REMOVAL] = next_removal;
        next_flags[UPF_GEN_ATTACH] = pin.attach_event;
    end

    always_ff @(posedge ref_clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            quota <= 1'b0;
            lowcur <= 1'b0;
            removal <= 1'b0;
            flags <= UPF_RST_FLAGS;
        end else begin
            quota <= next_quota;
            lowcur <= next_lowcur;
            removal <= next_removal;
            flags <= next_flags;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_q_b);

    a_quota_set: assert property (
        pin.quota_reached |=> flags[UPF_GEN_QUOTA])
        else $error("quota flag not set");
    a_quota_autoclr: assert property (
        (!pin.quota_reached && quota_auto_clr) |=> !flags[UPF_GEN_QUOTA])
        else $error("quota flag not auto cleared");
    a_cc_tracks: assert property (
        ##1 flags[UPF_GEN_CC] == $past(pin.const_current))
        else $error("cc bit does not track mode");
    a_switch_or: assert property (
        ##1 flags[UPF_GEN_SWITCH] ==
        $past(pin.switch_en_pin | pin.switch_enable_override))
        else $error("switch state not pin or override");
endmodule

// *** hw/upf_status_bank.sv ***
// Status flag bank for a two-port USB power switch
`timescale 1ns/100ps
// Contract
// - Port 2 overcurrent flag sets when current exceeds limit and minimum.
// - Read clears overcurrent flag once fault is gone; error clear too.
// - Setting the overcurrent flag asserts port 2 alert and enters Error.
// - A fault read can clear the alert output while the error bit stays set.
// - Back-voltage flag is zero unless bus exceeds both supplies by margin.
// - Constant-current bit reads one exactly while the port is in that mode.
module upf_status_bank
    import upf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register access
    input wire upf_bus_req_s bus_req,
    output upf_bus_rsp_s bus_rsp,
    // Port status inputs
    input wire upf_p2_cmp_s p2_cmp,
    input wire upf_port_in_s port1_in,
    input wire upf_port_in_s port2_in,
    // Port 2 alert, open drain, active low
    output logic alert_p2_o,
    output logic alert_p2_oe_b,
    // Port 2 Error state
    output logic error_state_p2
);
    logic rst_s1_b;
    logic rst_q_b;
    logic overcurrent_flag_p2;
    logic backvoltage_flag_p2;
    logic error_state_bit_p2;
    logic next_overcurrent;
    logic next_backvoltage;
    logic next_error;
    logic fault_p2;
    logic backv_cond;
    logic sel_fault;
    logic sel_p1;
    logic sel_p2;
    logic rd_fault;
    logic rd_p1;
    logic rd_p2;
    logic err_clr;
    logic [7:0] fault_flags;
    logic [7:0] port1_general_flags;
    logic [7:0] port2_general_flags;
    logic [7:0] next_rdata;

    // Reset release synchroniser
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_b <= 1'b0;
            rst_q_b <= 1'b0;
        end else begin
            rst_s1_b <= 1'b1;
            rst_q_b <= rst_s1_b;
        end
    end

    // Address decode
    assign sel_fault = bus_req.addr == UPF_OFS_P2_FAULT;
    assign sel_p1 = bus_req.addr == UPF_OFS_P1_GEN;
    assign sel_p2 = bus_req.addr == UPF_OFS_P2_GEN;
    assign rd_fault = bus_req.rd & sel_fault;
    assign rd_p1 = bus_req.rd & sel_p1;
    assign rd_p2 = bus_req.rd & sel_p2;
    assign err_clr = bus_req.wr & sel_fault & ~bus_req.wdata[UPF_FLT_ERROR];

    // Port 2 fault logic
    assign fault_p2 = p2_cmp.above_current_limit &
        p2_cmp.above_min_current;
    assign next_overcurrent = fault_p2 |
        (overcurrent_flag_p2 & ~rd_fault & ~err_clr);
    assign next_error = fault_p2 |
        (error_state_bit_p2 & ~err_clr);
    assign backv_cond = p2_cmp.vbus_above_source &
        p2_cmp.vbus_above_supply;
    assign next_backvoltage = backv_cond;

    always_comb begin
        fault_flags = 8'h00;
        fault_flags[UPF_FLT_ERROR] = error_state_bit_p2;
        fault_flags[UPF_FLT_BACKV] = backvoltage_flag_p2;
        fault_flags[UPF_FLT_OVERCUR] = overcurrent_flag_p2;
    end

    assign next_rdata = sel_fault ? fault_flags :
        sel_p1 ? port1_general_flags :
        sel_p2 ? port2_general_flags : UPF_RST_RDATA;

    always_ff @(posedge ref_clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            overcurrent_flag_p2 <= 1'b0;
            backvoltage_flag_p2 <= 1'b0;
            error_state_bit_p2 <= 1'b0;
            error_state_p2 <= 1'b0;
            alert_p2_o <= 1'b1;
            alert_p2_oe_b <= 1'b1;
            bus_rsp <= '0;
        end else begin
            overcurrent_flag_p2 <= next_overcurrent;
            backvoltage_flag_p2 <= next_backvoltage;
            error_state_bit_p2 <= next_error;
            error_state_p2 <= next_error;
            alert_p2_o <= 1'b0;
            alert_p2_oe_b <= ~next_overcurrent;
            bus_rsp.valid <= bus_req.rd;
            bus_rsp.data <= bus_req.rd ? next_rdata : UPF_RST_RDATA;
        end
    end

    upf_port_flags u_port1 (
        .ref_clk(ref_clk),
        .rst_q_b(rst_q_b),
        .pin(port1_in),
        .rd_clr(rd_p1),
        .flags(port1_general_flags)
    );

    upf_port_flags u_port2 (
        .ref_clk(ref_clk),
        .rst_q_b(rst_q_b),
        .pin(port2_in),
        .rd_clr(rd_p2),
        .flags(port2_general_flags)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_q_b);

    sequence s_fault_read;
        fault_p2 && rd_fault;
    endsequence
    sequence s_err_clear_clean;
        err_clr && !fault_p2;
    endsequence

    a_ov_set: assert property (
        fault_p2 |=> overcurrent_flag_p2)
        else $error("overcurrent flag not set");
    a_ov_no_set: assert property (
        (!overcurrent_flag_p2 && !fault_p2) |=> !overcurrent_flag_p2)
        else $error("overcurrent flag set without fault");
    a_ov_read_hold: assert property (
        s_fault_read |=> overcurrent_flag_p2)
        else $error("read cleared a present fault");
    a_ov_read_clear: assert property (
        (rd_fault && !fault_p2) |=> !overcurrent_flag_p2)
        else $error("read did not clear removed fault");
    a_err_clear_ov: assert property (
        s_err_clear_clean |=> !overcurrent_flag_p2 && !error_state_p2)
        else $error("error clear left flags set");
    a_alert_enter: assert property (
        fault_p2 |=> !alert_p2_oe_b && !alert_p2_o && error_state_p2)
        else $error("alert or error not entered");
    a_alert_indep: assert property (
        (rd_fault && !fault_p2 && error_state_bit_p2 && !err_clr)
        |=> alert_p2_oe_b && error_state_bit_p2)
        else $error("alert and error not independent");
    a_backv_zero: assert property (
        !backv_cond |=> !fault_flags[UPF_FLT_BACKV])
        else $error("back-voltage flag set without cause");
    a_read_answer: assert property (
        bus_req.rd |=> bus_rsp.valid ##1
        (bus_rsp.valid == $past(bus_req.rd)))
        else $error("read answer timing wrong");

    sequence s_ov_untouched;
        overcurrent_flag_p2 && !rd_fault && !err_clr;
    endsequence
    sequence s_err_untouched;
        error_state_bit_p2 && !err_clr;
    endsequence
    sequence s_answer_fault;
        bus_rsp.valid && bus_rsp.data == $past(fault_flags);
    endsequence
    sequence s_answer_p1;
        bus_rsp.valid && bus_rsp.data == $past(port1_general_flags);
    endsequence
    sequence s_answer_p2;
        bus_rsp.valid && bus_rsp.data == $past(port2_general_flags);
    endsequence

    // Flag and error bit hold and set, alert follow, error copy
    a_ov_hold: assert property (
        s_ov_untouched
        |=> overcurrent_flag_p2)
        else $error("overcurrent flag lost without clear");
    a_err_hold: assert property (
        s_err_untouched
        |=> error_state_bit_p2)
        else $error("error bit changed without clear");
    a_err_set: assert property (
        fault_p2
        |=> error_state_bit_p2)
        else $error("error bit not set by overcurrent");
    a_err_no_set: assert property (
        (!error_state_bit_p2 && !fault_p2)
        |=> !error_state_bit_p2)
        else $error("error bit set without overcurrent");
    a_err_wr_one: assert property (
        (bus_req.wr && sel_fault && bus_req.wdata[UPF_FLT_ERROR] &&
        error_state_bit_p2)
        |=> error_state_bit_p2)
        else $error("writing one cleared the error bit");
    a_alert_follow: assert property (
        ##1 alert_p2_oe_b != overcurrent_flag_p2)
        else $error("alert does not follow overcurrent flag");
    a_err_copy: assert property (
        ##1 error_state_p2 == error_state_bit_p2)
        else $error("error output differs from error bit");
    a_backv_set: assert property (
        backv_cond
        |=> fault_flags[UPF_FLT_BACKV])
        else $error("back-voltage flag not set");

    // Read answers
    a_rsp_fault: assert property (
        rd_fault
        |=> s_answer_fault)
        else $error("fault register read data wrong");
    a_rsp_p1: assert property (
        rd_p1
        |=> s_answer_p1)
        else $error("port 1 register read data wrong");
    a_rsp_p2: assert property (
        rd_p2
        |=> s_answer_p2)
        else $error("port 2 register read data wrong");
    a_rsp_unmapped: assert property (
        (bus_req.rd && !sel_fault && !sel_p1 && !sel_p2)
        |=> bus_rsp.data == UPF_RST_RDATA)
        else $error("unmapped read not zero");
    a_rsp_idle: assert property (
        !bus_req.rd
        |=> !bus_rsp.valid && bus_rsp.data == UPF_RST_RDATA)
        else $error("answer without read");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the status flag bank
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_top
    import upf_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    upf_bus_req_s bus_req;
    upf_bus_rsp_s bus_rsp;
    upf_p2_cmp_s p2_cmp;
    upf_port_in_s port_in [2];
    logic alert_p2_o, alert_p2_oe_b, error_state_p2;
    logic [7:0] d, ofs;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    always #2 ref_clk = ~ref_clk;

    upf_status_bank uut (.ref_clk(ref_clk), .rst_b(rst_b),
        .bus_req(bus_req), .bus_rsp(bus_rsp), .p2_cmp(p2_cmp),
        .port1_in(port_in[0]), .port2_in(port_in[1]),
        .alert_p2_o(alert_p2_o), .alert_p2_oe_b(alert_p2_oe_b),
        .error_state_p2(error_state_p2));
    upf_host_model host (.ref_clk(ref_clk), .bus_rsp(bus_rsp),
        .bus_req(bus_req));

    task automatic stop_test();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] x);
        host.rd(a, d);
        `CHK(d, x)
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic oc(input logic on);
        p2_cmp.above_current_limit = on;
        p2_cmp.above_min_current = on;
        idle(2);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            stop_test();
        end
    end

    initial begin
        p2_cmp = '0;
        port_in[0] = '0;
        port_in[0].quota_enable_bit = 1'b1;
        port_in[1] = port_in[0];
        idle(10);
        rst_b = 1'b1;
        idle(4);
        chk_rd(UPF_OFS_P2_FAULT, 8'h00);
        chk_rd(8'h20, 8'h00);
        `CHK({alert_p2_o, alert_p2_oe_b, error_state_p2}, 3'b010)
        $display("test reset done");
        // Overcurrent, read clear, error clear
        p2_cmp.above_current_limit = 1'b1;
        idle(2);
        chk_rd(UPF_OFS_P2_FAULT, 8'h00);
        p2_cmp.above_current_limit = 1'b0;
        p2_cmp.above_min_current = 1'b1;
        idle(2);
        chk_rd(UPF_OFS_P2_FAULT, 8'h00);
        oc(1'b1);
        `CHK({alert_p2_oe_b, error_state_p2}, 2'b01)
        chk_rd(UPF_OFS_P2_FAULT, 8'h81);
        chk_rd(UPF_OFS_P2_FAULT, 8'h81);
        oc(1'b0);
        chk_rd(UPF_OFS_P2_FAULT, 8'h81);
        chk_rd(UPF_OFS_P2_FAULT, 8'h80);
        `CHK({alert_p2_oe_b, error_state_p2}, 2'b11)
        host.req(UPF_OFS_P2_FAULT, 1'b0, 8'h80);
        oc(1'b1);
        `CHK({alert_p2_oe_b, error_state_p2}, 2'b01)
        oc(1'b0);
        `CHK(error_state_p2, 1'b1)
        host.req(UPF_OFS_P2_FAULT, 1'b0, 8'h00);
        idle(1);
        `CHK({alert_p2_oe_b, error_state_p2}, 2'b10)
        chk_rd(UPF_OFS_P2_FAULT, 8'h00);
        // Back-voltage needs both supplies exceeded
        for (int v = 1; v < 4; v++) begin
            p2_cmp.vbus_above_source = v[0];
            p2_cmp.vbus_above_supply = v[1];
            idle(2);
            chk_rd(UPF_OFS_P2_FAULT, (v == 3) ? 8'h02 : 8'h00);
        end
        p2_cmp = '0;
        $display("test port 2 fault done");
        for (int p = 0; p < 2; p++) begin
            ofs = p ? UPF_OFS_P2_GEN : UPF_OFS_P1_GEN;
            for (int k = 0; k < 4; k++) begin
                port_in[p].switch_en_pin = k[1];
                port_in[p].switch_enable_override = k[0];
                port_in[p].const_current = k[0];
                idle(2);
                chk_rd(ofs, {3'h0, k[0], |k[1:0], 3'h0});
            end
            port_in[p] = port_in[1 - p];
            // Quota done: read clear, reset bit, enable clear
            for (int m = 0; m < 3; m++) begin
                port_in[p].quota_reached = 1'b1;
                idle(1);
                port_in[p].quota_reached = 1'b0;
                port_in[p].quota_reset_bit = (m == 1);
                port_in[p].quota_enable_bit = (m != 2);
                idle(1);
                port_in[p].quota_reset_bit = 1'b0;
                port_in[p].quota_enable_bit = 1'b1;
                idle(2);
                chk_rd(ofs, (m == 0) ? 8'h80 : 8'h00);
                if (m == 0) begin
                    chk_rd(ofs, 8'h00);
                end
            end
            // Sticky low current and removal, live attach
            port_in[p].low_charge_current = 1'b1;
            port_in[p].removal_event = 1'b1;
            port_in[p].attach_event = 1'b1;
            idle(1);
            port_in[p].low_charge_current = 1'b0;
            port_in[p].removal_event = 1'b0;
            idle(2);
            chk_rd(ofs, 8'h07);
            port_in[p].attach_event = 1'b0;
            idle(2);
            chk_rd(ofs, 8'h00);
            $display("test general port %0d done", p + 1);
        end
        stop_test();
    end
endmodule

// *** tb/upf_host_model.sv ***
// Register host model for the status bank access port
`timescale 1ns/100ps
module upf_host_model
    import upf_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Access port
    input wire upf_bus_rsp_s bus_rsp,
    output upf_bus_req_s bus_req = '0
);
    // One request, held over the edge that takes it
    task automatic req(input logic [7:0] a, input logic r,
        input logic [7:0] w);
        @(negedge ref_clk);
        bus_req = {a, r, ~r, w};
        @(negedge ref_clk);
        bus_req = {~a, 2'b00, ~w};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req(a, 1'b1, 8'h00);
        repeat (2) if (bus_rsp.valid !== 1'b1) @(negedge ref_clk);
        d = (bus_rsp.valid === 1'b1) ? bus_rsp.data : 8'hxx;
    endtask
endmodule
